/* logic/accept_toggle.sv */
// Detects one full excursion of the acceptance switch away from and back to its rest level
`timescale 1ns/1ps
`default_nettype none
module accept_toggle (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic enable_in,
   input  wire logic level_in,
   output logic      done_out
);
   typedef enum {ACC_ARM, ACC_REST, ACC_AWAY} acc_state_e;

   acc_state_e state_q;
   logic       rest_q;

   // Rest level is learnt from the switch itself, so either polarity works
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q  <= ACC_ARM;
         rest_q   <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (state_q)
            ACC_ARM: begin
               if (enable_in) begin
                  rest_q  <= level_in;
                  state_q <= ACC_REST;
               end
            end
            ACC_REST: begin
               if (level_in != rest_q) begin
                  state_q <= ACC_AWAY;
               end
            end
            ACC_AWAY: begin
               if (level_in == rest_q) begin
                  done_out <= 1'b1;
                  state_q  <= ACC_REST;
               end
            end
            default: begin
               state_q <= ACC_ARM;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* logic/input_debounce.sv */
// Two-stage synchroniser and sample-based debouncer for a vector of slow inputs
`timescale 1ns/1ps
`default_nettype none
module input_debounce #(
   parameter int W       = 16,
   parameter int SAMPLES = 4
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic         tick_in,
   input  wire logic [W-1:0] raw_in,
   output logic      [W-1:0] stable_out,
   output logic              valid_out
);
   localparam int CW = $clog2(SAMPLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

   logic [W-1:0]  sync1_q;
   logic [W-1:0]  sync2_q;
   logic [W-1:0]  cand_q;
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // Any bounce restarts the count, so a value must hold over SAMPLES ticks
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cand_q <= '0;
         cnt_q  <= '0;
      end else if (sync2_q != cand_q) begin
         cand_q <= sync2_q;
         cnt_q  <= '0;
      end else if (tick_in && cnt_q != LAST) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stable_out <= '0;
         valid_out  <= 1'b0;
      end else if (tick_in && sync2_q == cand_q && cnt_q == LAST) begin
         stable_out <= cand_q;
         valid_out  <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* logic/switch_cfg_pkg.sv */
// Shared constants, register map and carrier types of the switch configuration loader
`default_nettype none
package switch_cfg_pkg;
   // Timing
   localparam int CLK_PERIOD_NS    = 8;
   localparam int DEBOUNCE_TICK_US = 1000;
   localparam int TICK_CYCLES      = DEBOUNCE_TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int DEBOUNCE_SAMPLES = 4;
   // Address ranges
   localparam logic [7:0] ADDR_MAX_FULL   = 8'h63;
   localparam logic [7:0] ADDR_MAX_RESTR  = 8'h3F;
   localparam logic [7:0] SHARED_ADDR_MAX = 8'h1F;
   localparam logic [2:0] BUS_MAX_FULL    = 3'h7;
   localparam logic [2:0] BUS_MAX_RESTR   = 3'h3;
   // Register map
   localparam logic [7:0] REG_CONFIG  = 8'h00;
   localparam logic [7:0] REG_SWITCH  = 8'h04;
   localparam logic [7:0] REG_STATE   = 8'h08;
   localparam logic [7:0] REG_EVENT   = 8'h0C;
   localparam logic [7:0] REG_MASK    = 8'h10;
   localparam logic [7:0] REG_CONTROL = 8'h14;
   // Event bits
   localparam int EV_W      = 4;
   localparam int EV_IDLE   = 0;
   localparam int EV_COMMIT = 1;
   localparam int EV_CONN   = 2;
   localparam int EV_MODE   = 3;
   localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
   // Control bits
   localparam int CTRL_W        = 2;
   localparam int CTRL_RESTRICT = 0;
   localparam int CTRL_COUPLER  = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

   typedef struct packed {
      logic [7:0] participant_addr;
      logic [2:0] bus_num;
      logic       remote_redundancy_select;
      logic       coupler_parallel_select;
   } sw_s;

   typedef struct packed {
      sw_s  sw;
      logic accept;
      logic loop_closed;
      logic bypass_jumper;
   } in_s;

   localparam int IN_W = $bits(in_s);
endpackage
`default_nettype wire

/* logic/switch_config_loader.sv */
// Front-panel switch and jumper configuration loader with connector check
// Function
// - Open insertion loop means connector absent; raise connector fault flag.
// - Fitted bypass jumper closes loop; connector always reported present.
// - Participant address is eight binary switches; valid 0..99, restricted 0..63.
// - Bus number is three binary switches; valid 0..7, restricted 0..3.
// - Redundancy switch 0 selects redundant remote bus, 1 single bus.
// - Changed settings adopted only after a full acceptance switch toggle.
// - First switch change forces idle until acceptance toggle commits settings.
// - Coupler variant: parallel switch 1 parallel mode, 0 simple coupler.
// - Fault indicator held on for local bus or module fault, bad mode; loader lights it only for connector fault or bad mode.
`timescale 1ns/1ps
`default_nettype none
module switch_config_loader #(
   parameter int TICK_CYCLES = switch_cfg_pkg::TICK_CYCLES,
   parameter int SAMPLES     = switch_cfg_pkg::DEBOUNCE_SAMPLES
) (
   input  wire logic                 clk_in,
   input  wire logic                 rst_b_in,
   input  wire switch_cfg_pkg::sw_s  sw_in,
   input  wire logic                 accept_sw_in,
   input  wire logic                 loop_closed_in,
   input  wire logic                 bypass_jumper_in,
   input  wire logic [7:0]           addr_in,
   input  wire logic [31:0]          wr_data_in,
   input  wire logic                 wr_en_in,
   input  wire logic                 rd_en_in,
   output logic      [31:0]          rd_data_out,
   output switch_cfg_pkg::sw_s       cfg_out,
   output logic                      redundant_bus_out,
   output logic                      parallel_coupler_out,
   output logic                      bus_idle_out,
   output logic                      conn_fault_out,
   output logic                      fault_ind_out,
   output logic                      irq_out
);
   typedef enum {ST_LOAD, ST_RUN, ST_IDLE} state_e;

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   localparam int EW = switch_cfg_pkg::EV_W;
   localparam int CW = switch_cfg_pkg::CTRL_W;

   function automatic logic above(input logic [7:0] value, input logic [7:0] limit);
      above = value > limit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [TW-1:0]         div_q;
   logic                  tick_q;
   switch_cfg_pkg::in_s   raw;
   switch_cfg_pkg::in_s   db;
   logic                  db_valid;
   logic                  commit_p;
   state_e                state_q;
   state_e                state_d;
   logic                  load;
   logic [EW-1:0]         ev_q;
   logic [EW-1:0]         ev_d;
   logic [EW-1:0]         ev_set;
   logic [EW-1:0]         mask_q;
   logic [CW-1:0]         ctrl_q;
   logic [7:0]            addr_max;
   logic [7:0]            bus_max;
   logic                  conn_fault_d;
   logic                  mode_fault_d;
   logic                  mode_fault_q;
   logic                  rd_ev;

   // Slow sample tick keeps the debounce counters narrow
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == TICK_LAST) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign raw = '{sw: sw_in, accept: accept_sw_in, loop_closed: loop_closed_in,
                  bypass_jumper: bypass_jumper_in};

   input_debounce #(
      .W       (switch_cfg_pkg::IN_W),
      .SAMPLES (SAMPLES)
   ) u_debounce (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (tick_q),
      .raw_in     (raw),
      .stable_out (db),
      .valid_out  (db_valid)
   );

   accept_toggle u_accept (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .enable_in (db_valid),
      .level_in  (db.accept),
      .done_out  (commit_p)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Settings are taken once at start-up, later only on a commit
   assign load = (state_q == ST_LOAD && db_valid) || commit_p;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_LOAD: begin
            if (db_valid) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!commit_p && db.sw != cfg_out) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (commit_p) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q      <= ST_LOAD;
         bus_idle_out <= 1'b1;
      end else begin
         state_q      <= state_d;
         bus_idle_out <= state_d != ST_RUN;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_out <= '0;
      end else if (load) begin
         cfg_out <= db.sw;
      end
   end

   // Mode outputs follow the committed word, never the live switches
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         redundant_bus_out    <= 1'b0;
         parallel_coupler_out <= 1'b0;
      end else begin
         redundant_bus_out    <= !cfg_out.remote_redundancy_select;
         parallel_coupler_out <= cfg_out.coupler_parallel_select
                                 && ctrl_q[switch_cfg_pkg::CTRL_COUPLER];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign addr_max = ctrl_q[switch_cfg_pkg::CTRL_RESTRICT] ? switch_cfg_pkg::ADDR_MAX_RESTR
                                                           : switch_cfg_pkg::ADDR_MAX_FULL;
   assign bus_max = {5'h00, ctrl_q[switch_cfg_pkg::CTRL_RESTRICT]
                    ? switch_cfg_pkg::BUS_MAX_RESTR : switch_cfg_pkg::BUS_MAX_FULL};

   // Jumper and loop are both debounced; before the first valid sample no fault
   assign conn_fault_d = db_valid && !(db.loop_closed || db.bypass_jumper);

   assign mode_fault_d = state_q != ST_LOAD && (
         above(cfg_out.participant_addr, addr_max)
      || above({5'h00, cfg_out.bus_num}, bus_max)
      || (cfg_out.participant_addr == 8'h00 && cfg_out.bus_num == 3'h0)
      || (cfg_out.coupler_parallel_select
          && !ctrl_q[switch_cfg_pkg::CTRL_COUPLER]));

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         conn_fault_out <= 1'b0;
         mode_fault_q   <= 1'b0;
         fault_ind_out  <= 1'b0;
      end else begin
         conn_fault_out <= conn_fault_d;
         mode_fault_q   <= mode_fault_d;
         fault_ind_out  <= conn_fault_d || mode_fault_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign rd_ev = rd_en_in && addr_in == switch_cfg_pkg::REG_EVENT;

   always_comb begin
      ev_set = '0;
      ev_set[switch_cfg_pkg::EV_IDLE]   = state_q == ST_RUN && state_d == ST_IDLE;
      ev_set[switch_cfg_pkg::EV_COMMIT] = commit_p;
      ev_set[switch_cfg_pkg::EV_CONN]   = conn_fault_d && !conn_fault_out;
      ev_set[switch_cfg_pkg::EV_MODE]   = mode_fault_d && !mode_fault_q;
      // A new event in the clearing read cycle survives
      ev_d = (rd_ev ? '0 : ev_q) | ev_set;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ev_q    <= '0;
         irq_out <= 1'b0;
      end else begin
         ev_q    <= ev_d;
         irq_out <= |(ev_d & mask_q);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mask_q <= switch_cfg_pkg::MASK_RESET;
         ctrl_q <= switch_cfg_pkg::CTRL_RESET;
      end else if (wr_en_in) begin
         if (addr_in == switch_cfg_pkg::REG_MASK) begin
            mask_q <= wr_data_in[EW-1:0];
         end
         if (addr_in == switch_cfg_pkg::REG_CONTROL) begin
            ctrl_q <= wr_data_in[CW-1:0];
         end
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= '0;
         if (rd_en_in) begin
            case (addr_in)
               switch_cfg_pkg::REG_CONFIG:  rd_data_out <= 32'(cfg_out);
               switch_cfg_pkg::REG_SWITCH:  rd_data_out <= 32'(db);
               switch_cfg_pkg::REG_STATE:   rd_data_out <= 32'({
                  !above(cfg_out.participant_addr, switch_cfg_pkg::SHARED_ADDR_MAX),
                  mode_fault_q, conn_fault_out, bus_idle_out, db_valid});
               switch_cfg_pkg::REG_EVENT:   rd_data_out <= 32'(ev_q);
               switch_cfg_pkg::REG_MASK:    rd_data_out <= 32'(mask_q);
               switch_cfg_pkg::REG_CONTROL: rd_data_out <= 32'(ctrl_q);
               default:                     rd_data_out <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   a_conn_fault_flag: assert property (
      (db_valid && !db.loop_closed && !db.bypass_jumper) |=> conn_fault_out && fault_ind_out)
      else $error("connector absent but fault flag low");
   a_bypass_present: assert property (
      db.bypass_jumper |=> !conn_fault_out)
      else $error("bypass jumper fitted but connector fault raised");
   a_addr_range: assert property (
      (state_q != ST_LOAD && above(cfg_out.participant_addr, addr_max)) |=> fault_ind_out)
      else $error("participant address out of range not flagged");
   a_bus_range: assert property (
      (state_q != ST_LOAD && above({5'h00, cfg_out.bus_num}, bus_max)) |=> fault_ind_out)
      else $error("bus number out of range not flagged");
   a_zero_pair: assert property (
      (state_q != ST_LOAD && cfg_out.participant_addr == 8'h00 && cfg_out.bus_num == 3'h0)
      |=> fault_ind_out)
      else $error("zero bus and participant address not flagged");
   a_redund_map: assert property (
      load |=> ##1 redundant_bus_out == !$past(db.sw.remote_redundancy_select, 2))
      else $error("redundancy mode does not follow committed switch");
   a_commit_only: assert property (
      (state_q != ST_LOAD && !commit_p) |=> $stable(cfg_out))
      else $error("configuration changed without acceptance toggle");
   a_idle_enter: assert property (
      (state_q == ST_RUN && db.sw != cfg_out && !commit_p) |=> bus_idle_out [*2])
      else $error("switch change did not force idle");
   a_idle_hold: assert property (
      (state_q == ST_IDLE && !commit_p) |=> bus_idle_out)
      else $error("idle left without commit");
   a_parallel_mode: assert property (
      (load && ctrl_q[switch_cfg_pkg::CTRL_COUPLER]) ##1 ctrl_q[switch_cfg_pkg::CTRL_COUPLER]
      |=> parallel_coupler_out == $past(db.sw.coupler_parallel_select, 2))
      else $error("coupler mode does not follow committed switch");
   a_debounce_tick: assert property (
      $changed(db) |-> $past(tick_q))
      else $error("debounced inputs changed off the sample tick");
   a_fault_hold: assert property (
      mode_fault_d [*2] |=> $past(fault_ind_out) && fault_ind_out)
      else $error("fault indicator not held during mode fault");

   c_commit: cover property (commit_p);
   c_idle_entry: cover property (state_q == ST_RUN ##1 state_q == ST_IDLE);
   c_conn_fault: cover property ($rose(conn_fault_out));
   c_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

/* testbench/bus_interface_switch_config_test.sv */
// Self-checking bench for the switch configuration loader
`timescale 1ns/1ps
`default_nettype none
module bus_interface_switch_config_test;
   logic                clk_in;
   logic                rst_b_in;
   switch_cfg_pkg::sw_s want_sw;
   switch_cfg_pkg::sw_s sw_in;
   switch_cfg_pkg::sw_s cfg_out;
   logic                want_acc;
   logic                plugged;
   logic                bypass;
   logic                glitch;
   logic                rest;
   logic                accept_sw_in;
   logic                loop_closed_in;
   logic                bypass_jumper_in;
   logic [7:0]          addr_in;
   logic [31:0]         wr_data_in;
   logic                wr_en_in;
   logic                rd_en_in;
   logic [31:0]         rd_data_out;
   logic                redundant_bus_out;
   logic                parallel_coupler_out;
   logic                bus_idle_out;
   logic                conn_fault_out;
   logic                fault_ind_out;
   logic                irq_out;
   logic [31:0]         d;
   int                  num_errors;
   int                  checks;
   int                  cycles;

   panel_model u_panel_model (.clk_in(clk_in), .want_sw_in(want_sw), .want_acc_in(want_acc),
      .plugged_in(plugged), .bypass_in(bypass), .glitch_in(glitch), .sw_out(sw_in),
      .acc_out(accept_sw_in), .loop_out(loop_closed_in), .bypass_out(bypass_jumper_in));

   // Short debounce counts keep each settle to a few dozen clocks
   switch_config_loader #(.TICK_CYCLES(8), .SAMPLES(2)) u_switch_config_loader (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .sw_in(sw_in), .accept_sw_in(accept_sw_in),
      .loop_closed_in(loop_closed_in), .bypass_jumper_in(bypass_jumper_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .cfg_out(cfg_out), .redundant_bus_out(redundant_bus_out),
      .parallel_coupler_out(parallel_coupler_out), .bus_idle_out(bus_idle_out),
      .conn_fault_out(conn_fault_out), .fault_ind_out(fault_ind_out), .irq_out(irq_out));

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      addr_in    <= a;
      wr_data_in <= v;
      wr_en_in   <= 1'b1;
      @(posedge clk_in);
      wr_en_in   <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 v = rd_data_out;
   endtask

   task automatic wait_idle(input logic lvl);
      int n;
      n = 0;
      #1;
      while (bus_idle_out !== lvl && n < 200) begin
         @(posedge clk_in);
         #1 n++;
      end
      chk({31'h0, bus_idle_out}, {31'h0, lvl});
   endtask

   function automatic switch_cfg_pkg::sw_s mk(input logic [7:0] a, input logic [2:0] b,
                                              input logic r, input logic p);
      return {a, b, r, p};
   endfunction

   function automatic logic mode_bad(input switch_cfg_pkg::sw_s s, input logic [1:0] c);
      logic [7:0] am;
      logic [2:0] bm;
      am = c[0] ? switch_cfg_pkg::ADDR_MAX_RESTR : switch_cfg_pkg::ADDR_MAX_FULL;
      bm = c[0] ? switch_cfg_pkg::BUS_MAX_RESTR : switch_cfg_pkg::BUS_MAX_FULL;
      return s.participant_addr > am || s.bus_num > bm || {s.participant_addr, s.bus_num} == 0
             || (s.coupler_parallel_select && !c[1]);
   endfunction

   // Change settings, prove nothing is adopted on half a toggle, then finish the toggle
   task automatic commit(input switch_cfg_pkg::sw_s s, input logic [1:0] c);
      switch_cfg_pkg::sw_s old;
      wr(switch_cfg_pkg::REG_CONTROL, {30'h0, c});
      // Clears leftovers, including a mode fault raised by the control write
      rd(switch_cfg_pkg::REG_EVENT, d);
      old = cfg_out;
      if (s == old) s.participant_addr[0] = ~s.participant_addr[0];
      @(posedge clk_in);
      want_sw <= s;
      wait_idle(1'b1);
      chk(32'(cfg_out), 32'(old));
      @(posedge clk_in);
      want_acc <= ~rest;
      repeat (50) @(posedge clk_in);
      #1 chk({31'h0, bus_idle_out}, 32'h1);
      chk(32'(cfg_out), 32'(old));
      @(posedge clk_in);
      want_acc <= rest;
      wait_idle(1'b0);
      repeat (3) @(posedge clk_in);
      #1 chk(32'(cfg_out), 32'(s));
      chk({31'h0, redundant_bus_out}, {31'h0, !s.remote_redundancy_select});
      chk({31'h0, parallel_coupler_out}, {31'h0, s.coupler_parallel_select & c[1]});
      chk({31'h0, fault_ind_out}, {31'h0, mode_bad(s, c)});
      rd(switch_cfg_pkg::REG_STATE, d);
      chk({27'h0, d[4:0]}, {27'h0, s.participant_addr <= switch_cfg_pkg::SHARED_ADDR_MAX,
                            mode_bad(s, c), 3'h1});
      rd(switch_cfg_pkg::REG_CONFIG, d);
      chk(d, 32'(s));
      rd(switch_cfg_pkg::REG_EVENT, d);
      chk(d, {28'h0, mode_bad(s, c) & !mode_bad(old, c), 3'h3});
   endtask

   task automatic do_reset(input logic acc);
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      want_acc <= acc;
      rest = acc;
      repeat (9) @(posedge clk_in);
      #1 chk({28'h0, bus_idle_out, conn_fault_out, fault_ind_out, irq_out}, 32'h8);
      chk(32'(cfg_out), 32'h0);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      wait_idle(1'b0);
      repeat (3) @(posedge clk_in);
      #1 chk(32'(cfg_out), 32'(want_sw));
      wr(switch_cfg_pkg::REG_CONFIG, 32'h1FFF);
      rd(switch_cfg_pkg::REG_CONFIG, d);
      chk(d, 32'(want_sw));
      rd(switch_cfg_pkg::REG_SWITCH, d);
      chk(d, 32'({want_sw, acc, 2'h2}));
      rd(switch_cfg_pkg::REG_MASK, d);
      chk(d, 32'(switch_cfg_pkg::MASK_RESET));
      rd(switch_cfg_pkg::REG_CONTROL, d);
      chk(d, 32'(switch_cfg_pkg::CTRL_RESET));
      rd(8'h18, d);
      chk(d, 32'h0);
      $display("test reset done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   initial begin
      {rst_b_in, want_acc, bypass, glitch, wr_en_in, rd_en_in} = '0;
      {addr_in, wr_data_in, num_errors, checks} = '0;
      plugged = 1'b1;
      void'($urandom(32'h0462));
      want_sw = mk(8'($urandom_range(1, 99)), 3'($urandom_range(0, 7)), 1'b0, 1'b0);
      do_reset(1'b0);
      repeat (4) begin
         commit(mk(8'($urandom_range(1, 99)), 3'($urandom_range(0, 7)),
                   1'($urandom_range(0, 1)), 1'b0), 2'h0);
      end
      commit(mk(8'h46, 3'h1, 1'b0, 1'b0), 2'h1);
      commit(mk(8'h3F, 3'h3, 1'b1, 1'b0), 2'h1);
      commit(mk(8'h32, 3'h4, 1'b0, 1'b0), 2'h1);
      commit(mk(8'h63, 3'h7, 1'b0, 1'b0), 2'h0);
      commit(mk(8'h64, 3'h0, 1'b0, 1'b0), 2'h0);
      commit(mk(8'h00, 3'h0, 1'b0, 1'b0), 2'h0);
      commit(mk(8'h1F, 3'h2, 1'b0, 1'b1), 2'h0);
      commit(mk(8'h1E, 3'h2, 1'b1, 1'b1), 2'h2);
      commit(mk(8'h00, 3'h1, 1'b1, 1'b0), 2'h0);
      $display("test commit done");
      @(posedge clk_in);
      glitch <= 1'b1;
      repeat (3) @(posedge clk_in);
      glitch <= 1'b0;
      repeat (60) @(posedge clk_in);
      #1 chk({31'h0, bus_idle_out}, 32'h0);
      $display("test glitch done");
      rd(switch_cfg_pkg::REG_EVENT, d);
      wr(switch_cfg_pkg::REG_MASK, 32'h0);
      plugged <= 1'b0;
      repeat (60) @(posedge clk_in);
      #1 chk({31'h0, conn_fault_out}, 32'h1);
      chk({31'h0, fault_ind_out}, 32'h1);
      chk({31'h0, irq_out}, 32'h0);
      wr(switch_cfg_pkg::REG_MASK, 32'h4);
      repeat (2) @(posedge clk_in);
      #1 chk({31'h0, irq_out}, 32'h1);
      rd(switch_cfg_pkg::REG_EVENT, d);
      chk(d, 32'h4);
      repeat (2) @(posedge clk_in);
      #1 chk({31'h0, irq_out}, 32'h0);
      bypass <= 1'b1;
      repeat (60) @(posedge clk_in);
      #1 chk({31'h0, conn_fault_out}, 32'h0);
      chk({31'h0, fault_ind_out}, 32'h0);
      plugged <= 1'b1;
      bypass  <= 1'b0;
      $display("test connector done");
      do_reset(1'b1);
      commit(mk(8'($urandom_range(1, 99)), 3'h5, 1'b0, 1'b0), 2'h0);
      $display("test high rest done");
      wrap_up();
   end
endmodule
`default_nettype wire

/* testbench/panel_model.sv */
// Front-panel switch, jumper and connector model feeding the loader's raw inputs
`timescale 1ns/1ps
`default_nettype none
module panel_model (
   input  wire logic                clk_in,
   input  wire switch_cfg_pkg::sw_s want_sw_in,
   input  wire logic                want_acc_in,
   input  wire logic                plugged_in,
   input  wire logic                bypass_in,
   input  wire logic                glitch_in,
   output switch_cfg_pkg::sw_s      sw_out,
   output logic                     acc_out,
   output logic                     loop_out,
   output logic                     bypass_out
);
   // Glitch flips the lowest address contact to mimic switch bounce
   always @(posedge clk_in) begin
      sw_out     <= want_sw_in ^ {7'h00, glitch_in, 5'h00};
      acc_out    <= want_acc_in;
      // Loop sense sits ahead of the jumper, so the loader must honour the jumper itself
      loop_out   <= plugged_in;
      bypass_out <= bypass_in;
   end
endmodule
`default_nettype wire
